// ==== pio_fall_det.sv ====
// Purpose: Falling edge detector for the third port interrupt inputs.
// Assumes: Pin inputs synchronous to the clock.
// Notes: A pin is a source only while direction and data bits are both 0.
`timescale 1ns/1ps

module pio_fall_det #(
    parameter int W = 8
) (
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic [W-1:0] pin_in,
    input wire logic [W-1:0] dir_in,
    input wire logic [W-1:0] data_in,
    output logic [W-1:0] enable_out,
    output logic [W-1:0] fall_out
);

    logic [W-1:0] prev_q;

    // Previous pin level, idle high so reset makes no edge
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            prev_q <= W'(pio_pkg::EDGE_PREV_RESET);
        end else begin
            prev_q <= pin_in;
        end
    end

    // Source qualification and edge only, never level
    always_comb begin
        enable_out = ~dir_in & ~data_in;
        fall_out = prev_q & ~pin_in & enable_out;
    end

endmodule : pio_fall_det

// ==== pio_pins_model.sv ====
// Purpose: Board side of one port: pin level from all drivers.
// Assumes: Every pin has a pull-up on the board.
// Notes: Device drive wins over the board driver.
`timescale 1ns/1ps

module pio_pins_model #(
    parameter int W = 8
) (
    input wire logic [W-1:0] drive_in,
    input wire logic [W-1:0] oe_in,
    input wire logic [W-1:0] ext_en_in,
    input wire logic [W-1:0] ext_val_in,
    output logic [W-1:0] level_out
);
    // Undriven lines float up through the pull-up
    assign level_out = (oe_in & drive_in) | (~oe_in & ((ext_en_in & ext_val_in) | ~ext_en_in));
endmodule : pio_pins_model

// ==== pio_pkg.sv ====
// Purpose: Shared constants for the parallel I/O ports block.
// Assumes: Byte addressing on the register port, one 32-bit word per register.
// Notes: Register index times four gives the byte address.

package pio_pkg;

    // ********************************************************
    // Port widths
    // ********************************************************
    localparam int FIRST_W = 7;
    localparam int SECOND_W = 8;
    localparam int THIRD_W = 8;
    localparam int FOURTH_W = 5;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CHAN_W = 3;

    // ********************************************************
    // Register indices and byte addresses
    // ********************************************************
    localparam logic [ADDR_W-1:0] IDX_FIRST_DATA = 8'h00;
    localparam logic [ADDR_W-1:0] IDX_SECOND_DATA = 8'h01;
    localparam logic [ADDR_W-1:0] IDX_THIRD_DATA = 8'h02;
    localparam logic [ADDR_W-1:0] IDX_FOURTH_INPUT = 8'h03;
    localparam logic [ADDR_W-1:0] IDX_FIRST_DIR = 8'h04;
    localparam logic [ADDR_W-1:0] IDX_SECOND_DIR = 8'h05;
    localparam logic [ADDR_W-1:0] IDX_THIRD_DIR = 8'h06;
    localparam logic [ADDR_W-1:0] IDX_INT_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] IDX_INT_MASK = 8'h09;
    localparam logic [1:0] ADDR_SHIFT = 2'h2;

    // ********************************************************
    // Reset values
    // ********************************************************
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] EDGE_PREV_RESET = 8'hff;

    // ********************************************************
    // Second port sharing: field masks per peripheral
    // ********************************************************
    localparam logic [SECOND_W-1:0] SHARE_SPI = 8'h0f;
    localparam logic [SECOND_W-1:0] SHARE_PWM = 8'h30;
    localparam logic [SECOND_W-1:0] SHARE_TMR = 8'hc0;

    // Byte address of a register index
    function automatic logic [ADDR_W-1:0] pio_byte_addr(input logic [ADDR_W-1:0] idx);
        pio_byte_addr = idx << ADDR_SHIFT;
    endfunction : pio_byte_addr

endpackage : pio_pkg

// ==== pio_port.sv ====
// Purpose: One bidirectional port: data and direction registers, pin drive.
// Assumes: Pin inputs synchronous to the clock.
// Notes: Data register has no reset; direction clears on reset.
`timescale 1ns/1ps

module pio_port #(
    parameter int W = 8
) (
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic data_we_in,
    input wire logic dir_we_in,
    input wire logic [W-1:0] wdata_in,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] data_out,
    output logic [W-1:0] dir_out,
    output logic [W-1:0] read_out
);

    // Data latch, untouched by reset
    always_ff @(posedge ref_clk_in) begin
        if (data_we_in) begin
            data_out <= wdata_in;
        end
    end

    // Direction: 1 drives the pin, 0 listens
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            dir_out <= W'(pio_pkg::DIR_RESET);
        end else if (dir_we_in) begin
            dir_out <= wdata_in;
        end
    end

    // Outputs read back the latch, inputs read the pin
    always_comb begin
        read_out = (dir_out & data_out) | (~dir_out & pin_in);
    end

endmodule : pio_port

// ==== pio_top.sv ====
// Purpose: Parallel I/O ports with register port, third port interrupts.
// Assumes: Single clock; pins and bus inputs synchronous to ref_clk_in.
// Notes: Read data appear in the cycle after the read strobe.
//
// How it works
// - A 7-bit bidirectional first port has data at index 0 and direction at index 4.
// - A direction bit of 0 makes the pin an input and 1 makes it an output.
// - An output pin is driven with its data register bit.
// - Reading the data register of an input pin returns the pin level.
// - Reset clears all direction registers and leaves data registers as they were.
// - An 8-bit bidirectional second port has data at index 1 and direction at index 5.
// - Second port bits 5-4 go to the PWMs, 7-6 to the timer and 3-0 to the SPI.
// - An 8-bit bidirectional third port has data at index 2 and direction at index 6.
// - The third port source pin inputs are ANDed into the CPU external interrupt line; other pins count as high.
// - The third port has its own request latch, apart from the interrupt pin.
// - Third port interrupts respond to falling edges only.
// - A third port pin is a source only while its direction and data bits are 0.
// - A third port pin set as output never raises a port interrupt.
// - A 5-bit input-only fourth port at index 3 shares pins with the analog inputs.
// - While the converter runs, its selected fourth port pin reads as 0.
// - An enabled third port falling edge wakes the device from stop mode.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps

module pio_top #(
    parameter int FIRST_W = pio_pkg::FIRST_W,
    parameter int SECOND_W = pio_pkg::SECOND_W,
    parameter int THIRD_W = pio_pkg::THIRD_W,
    parameter int FOURTH_W = pio_pkg::FOURTH_W
) (
    input wire logic ref_clk_in,
    input wire logic reset_in,
    // Register port
    input wire logic [pio_pkg::ADDR_W-1:0] addr_in,
    input wire logic [pio_pkg::DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [pio_pkg::DATA_W-1:0] rdata_out,
    // First port pins
    input wire logic [FIRST_W-1:0] first_pin_in,
    output logic [FIRST_W-1:0] first_pin_out,
    output logic [FIRST_W-1:0] first_pin_oe_out,
    // Second port pins
    input wire logic [SECOND_W-1:0] second_pin_in,
    output logic [SECOND_W-1:0] second_pin_out,
    output logic [SECOND_W-1:0] second_pin_oe_out,
    // Second port sharing with peripherals
    input wire logic spi_en_in,
    input wire logic pwm_en_in,
    input wire logic tmr_en_in,
    input wire logic [SECOND_W-1:0] periph_out_in,
    input wire logic [SECOND_W-1:0] periph_oe_in,
    output logic [SECOND_W-1:0] periph_pin_out,
    // Third port pins
    input wire logic [THIRD_W-1:0] third_pin_in,
    output logic [THIRD_W-1:0] third_pin_out,
    output logic [THIRD_W-1:0] third_pin_oe_out,
    // Fourth port and converter state
    input wire logic [FOURTH_W-1:0] analog_inputs_0_to_4_in,
    input wire logic adc_active_in,
    input wire logic [pio_pkg::CHAN_W-1:0] adc_channel_in,
    // CPU side
    input wire logic stop_mode_in,
    output logic cpu_irq_line_out,
    output logic stop_wake_out,
    output logic irq_out
);

    // ********************************************************
    // Address decode
    // ********************************************************
    // Decoded register selects
    logic hit_first_data;
    logic hit_second_data;
    logic hit_third_data;
    logic hit_fourth_input;
    logic hit_first_dir;
    logic hit_second_dir;
    logic hit_third_dir;
    logic hit_status;
    logic hit_mask;

    // One compare per register byte address
    always_comb begin
        hit_first_data = addr_in == pio_pkg::pio_byte_addr(pio_pkg::IDX_FIRST_DATA);
        hit_second_data = addr_in == pio_pkg::pio_byte_addr(pio_pkg::IDX_SECOND_DATA);
        hit_third_data = addr_in == pio_pkg::pio_byte_addr(pio_pkg::IDX_THIRD_DATA);
        hit_fourth_input = addr_in == pio_pkg::pio_byte_addr(pio_pkg::IDX_FOURTH_INPUT);
        hit_first_dir = addr_in == pio_pkg::pio_byte_addr(pio_pkg::IDX_FIRST_DIR);
        hit_second_dir = addr_in == pio_pkg::pio_byte_addr(pio_pkg::IDX_SECOND_DIR);
        hit_third_dir = addr_in == pio_pkg::pio_byte_addr(pio_pkg::IDX_THIRD_DIR);
        hit_status = addr_in == pio_pkg::pio_byte_addr(pio_pkg::IDX_INT_STATUS);
        hit_mask = addr_in == pio_pkg::pio_byte_addr(pio_pkg::IDX_INT_MASK);
    end

    // ********************************************************
    // First port
    // ********************************************************
    // First port state
    logic [FIRST_W-1:0] first_data;
    logic [FIRST_W-1:0] first_dir;
    logic [FIRST_W-1:0] first_read;

    // Only the low seven write bits reach the port
    pio_port #(
        .W(FIRST_W)
    ) u_first (
        .ref_clk_in(ref_clk_in),
        .reset_in(reset_in),
        .data_we_in(wr_in && hit_first_data),
        .dir_we_in(wr_in && hit_first_dir),
        .wdata_in(wdata_in[FIRST_W-1:0]),
        .pin_in(first_pin_in),
        .data_out(first_data),
        .dir_out(first_dir),
        .read_out(first_read)
    );

    // Registered pin drive
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            first_pin_out <= '0;
            first_pin_oe_out <= '0;
        end else begin
            first_pin_out <= first_data;
            first_pin_oe_out <= first_dir;
        end
    end

    // ********************************************************
    // Second port
    // ********************************************************
    // Second port state and peripheral hand-over
    logic [SECOND_W-1:0] second_data;
    logic [SECOND_W-1:0] second_dir;
    logic [SECOND_W-1:0] second_read;
    logic [SECOND_W-1:0] share_sel;

    // Second port registers, all eight bits writable
    pio_port #(
        .W(SECOND_W)
    ) u_second (
        .ref_clk_in(ref_clk_in),
        .reset_in(reset_in),
        .data_we_in(wr_in && hit_second_data),
        .dir_we_in(wr_in && hit_second_dir),
        .wdata_in(wdata_in[SECOND_W-1:0]),
        .pin_in(second_pin_in),
        .data_out(second_data),
        .dir_out(second_dir),
        .read_out(second_read)
    );

    // Bits handed to an enabled peripheral
    always_comb begin
        share_sel = ({SECOND_W{spi_en_in}} & SECOND_W'(pio_pkg::SHARE_SPI))
            | ({SECOND_W{pwm_en_in}} & SECOND_W'(pio_pkg::SHARE_PWM))
            | ({SECOND_W{tmr_en_in}} & SECOND_W'(pio_pkg::SHARE_TMR));
    end

    // Peripheral takes the pin where shared, else the port registers
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            second_pin_out <= '0;
            second_pin_oe_out <= '0;
        end else begin
            second_pin_out <= (share_sel & periph_out_in) | (~share_sel & second_data);
            second_pin_oe_out <= (share_sel & periph_oe_in) | (~share_sel & second_dir);
        end
    end

    // Pin levels returned to the peripherals
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            periph_pin_out <= '0;
        end else begin
            periph_pin_out <= second_pin_in;
        end
    end

    // ********************************************************
    // Third port
    // ********************************************************
    // Third port state and qualified edges
    logic [THIRD_W-1:0] third_data;
    logic [THIRD_W-1:0] third_dir;
    logic [THIRD_W-1:0] third_read;
    logic [THIRD_W-1:0] third_src_en;
    logic [THIRD_W-1:0] third_fall;

    // Third port registers, also gating the interrupt sources
    pio_port #(
        .W(THIRD_W)
    ) u_third (
        .ref_clk_in(ref_clk_in),
        .reset_in(reset_in),
        .data_we_in(wr_in && hit_third_data),
        .dir_we_in(wr_in && hit_third_dir),
        .wdata_in(wdata_in[THIRD_W-1:0]),
        .pin_in(third_pin_in),
        .data_out(third_data),
        .dir_out(third_dir),
        .read_out(third_read)
    );

    // Registered pin drive
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            third_pin_out <= '0;
            third_pin_oe_out <= '0;
        end else begin
            third_pin_out <= third_data;
            third_pin_oe_out <= third_dir;
        end
    end

    // Edge qualified by direction and data bits
    pio_fall_det #(
        .W(THIRD_W)
    ) u_fall (
        .ref_clk_in(ref_clk_in),
        .reset_in(reset_in),
        .pin_in(third_pin_in),
        .dir_in(third_dir),
        .data_in(third_data),
        .enable_out(third_src_en),
        .fall_out(third_fall)
    );

    // AND of enabled pins; a disabled pin counts as high
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            cpu_irq_line_out <= 1'b1;
        end else begin
            cpu_irq_line_out <= &(third_pin_in | ~third_src_en);
        end
    end

    // Wake pulse on an enabled edge while stopped
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            stop_wake_out <= 1'b0;
        end else begin
            stop_wake_out <= stop_mode_in && (|third_fall);
        end
    end

    // ********************************************************
    // Fourth port
    // ********************************************************
    // Input-only port view and converter channel mask
    logic [FOURTH_W-1:0] fourth_read;
    logic [FOURTH_W-1:0] adc_sel;

    // Selected converter channel reads as zero while active
    always_comb begin
        adc_sel = '0;
        if (adc_active_in && (32'(adc_channel_in) < FOURTH_W)) begin
            adc_sel = FOURTH_W'(1) << adc_channel_in;
        end
        fourth_read = analog_inputs_0_to_4_in & ~adc_sel;
    end

    // ********************************************************
    // Interrupt status and mask
    // ********************************************************
    // Request latch, mask and write-one-to-clear bits
    logic [THIRD_W-1:0] status_q;
    logic [THIRD_W-1:0] mask_q;
    logic [THIRD_W-1:0] status_clr;

    // Clear bits only on a write to the status register
    always_comb begin
        status_clr = (wr_in && hit_status) ? wdata_in[THIRD_W-1:0] : '0;
    end

    // Port request latch, write one to clear, new edge wins
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            status_q <= THIRD_W'(pio_pkg::STATUS_RESET);
        end else begin
            status_q <= (status_q & ~status_clr) | third_fall;
        end
    end

    // Mask, 1 lets the bit reach irq_out
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            mask_q <= THIRD_W'(pio_pkg::MASK_RESET);
        end else if (wr_in && hit_mask) begin
            mask_q <= wdata_in[THIRD_W-1:0];
        end
    end

    // Level interrupt from unmasked latched requests
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(status_q & mask_q);
        end
    end

    // ********************************************************
    // Read data, one cycle after the strobe
    // ********************************************************
    // Selected register before the output flop
    logic [pio_pkg::DATA_W-1:0] rd_mux;

    // Narrow registers zero-extended; unmapped reads zero
    always_comb begin
        rd_mux = '0;
        if (hit_first_data) begin
            rd_mux = pio_pkg::DATA_W'(first_read);
        end else if (hit_second_data) begin
            rd_mux = pio_pkg::DATA_W'(second_read);
        end else if (hit_third_data) begin
            rd_mux = pio_pkg::DATA_W'(third_read);
        end else if (hit_fourth_input) begin
            rd_mux = pio_pkg::DATA_W'(fourth_read);
        end else if (hit_first_dir) begin
            rd_mux = pio_pkg::DATA_W'(first_dir);
        end else if (hit_second_dir) begin
            rd_mux = pio_pkg::DATA_W'(second_dir);
        end else if (hit_third_dir) begin
            rd_mux = pio_pkg::DATA_W'(third_dir);
        end else if (hit_status) begin
            rd_mux = pio_pkg::DATA_W'(status_q);
        end else if (hit_mask) begin
            rd_mux = pio_pkg::DATA_W'(mask_q);
        end
    end

    // Data stand only in the cycle after a read
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            rdata_out <= '0;
        end else if (rd_in) begin
            rdata_out <= rd_mux;
        end else begin
            rdata_out <= '0;
        end
    end

endmodule : pio_top

// ==== pio_top_sva.sv ====
// Purpose: Port-level checks for the parallel I/O ports block.
// Assumes: One clock, synchronous active-high reset, byte address = index*4.
// Notes: Sees only the top ports; bound onto every pio_top.
`timescale 1ns/1ps

module pio_top_chk (
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [31:0] rdata_out,
    input wire logic [6:0] first_pin_oe_out,
    input wire logic [7:0] second_pin_oe_out,
    input wire logic [7:0] third_pin_in,
    input wire logic [7:0] third_pin_out,
    input wire logic [7:0] third_pin_oe_out,
    input wire logic adc_active_in,
    input wire logic [2:0] adc_channel_in,
    input wire logic stop_mode_in,
    input wire logic cpu_irq_line_out,
    input wire logic stop_wake_out,
    input wire logic irq_out
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);

    AST_DIR_RESET: assert property (
        $fell(reset_in) |-> (first_pin_oe_out | second_pin_oe_out | third_pin_oe_out) == 8'h00)
        else $error("drive enables not cleared by reset");
    AST_FIRST_DIR: assert property (
        wr_in && addr_in == 8'h10 |-> ##2 first_pin_oe_out == $past(wdata_in[6:0], 2))
        else $error("first port enables do not follow direction write");
    AST_THIRD_DRIVE: assert property (
        wr_in && addr_in == 8'h08 |-> ##2
        ((third_pin_out ^ $past(wdata_in[7:0], 2)) & third_pin_oe_out) == 8'h00)
        else $error("third port output pin differs from data");
    AST_FIRST_BIT7: assert property (
        rd_in && (addr_in == 8'h00 || addr_in == 8'h10) |=> rdata_out[31:7] == 25'h0)
        else $error("first port upper bits not zero");
    AST_ADC_ZERO: assert property (
        rd_in && addr_in == 8'h0c && adc_active_in && adc_channel_in < 3'h5 |=>
        rdata_out[$past(adc_channel_in)] == 1'b0)
        else $error("selected analog pin not read as zero");
    AST_IRQ_LINE: assert property (
        $past(third_pin_in) == 8'hff |-> cpu_irq_line_out)
        else $error("interrupt line low with all pins high");
    AST_WAKE: assert property (
        stop_wake_out |-> $past(stop_mode_in) &&
        ($past(third_pin_in, 2) & ~$past(third_pin_in)) != 8'h00)
        else $error("wake pulse without a falling pin in stop");
    AST_NO_WAKE_OUT: assert property (
        (third_pin_oe_out == 8'hff) [*3] |-> !stop_wake_out)
        else $error("wake from a port set as output");
    AST_MASK_OFF: assert property (
        wr_in && addr_in == 8'h24 && wdata_in[7:0] == 8'h00 |-> ##2 !irq_out)
        else $error("interrupt stays high after mask cleared");

    // Main scenarios reached
    COV_WAKE: cover property (stop_wake_out);
    COV_IRQ: cover property ($rose(irq_out));
    COV_ADC: cover property (rd_in && addr_in == 8'h0c && adc_active_in);
endmodule : pio_top_chk

bind pio_top pio_top_chk i_chk (.ref_clk_in, .reset_in, .addr_in, .wdata_in, .wr_in,
    .rd_in, .rdata_out, .first_pin_oe_out, .second_pin_oe_out, .third_pin_in,
    .third_pin_out, .third_pin_oe_out, .adc_active_in, .adc_channel_in, .stop_mode_in,
    .cpu_irq_line_out, .stop_wake_out, .irq_out);

// ==== test_parallel_io_ports.sv ====
// Purpose: Register and pin tests of the parallel I/O ports block.
// Assumes: 40 MHz clock, reset held 20 cycles.
// Notes: Pins pass through board models with pull-ups.
`timescale 1ns/1ps

module test_parallel_io_ports;
    logic ref_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [7:0] addr_in = 8'h00;
    logic [31:0] wdata_in = 32'h0;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [31:0] rdata_out;
    logic [6:0] a_in, a_out, a_oe;
    logic [7:0] b_in, b_out, b_oe, c_in, c_out, c_oe, b_per, m;
    logic [7:0] ext_en = 8'hff, ext_val = 8'hff, c_val = 8'hff, p_out = 8'h5a, p_oe = 8'hff;
    logic [4:0] an_in = 5'h1f;
    logic [2:0] chan = 3'h0;
    logic spi_en = 0, pwm_en = 0, tmr_en = 0, adc_on = 0, stop_in = 0;
    logic irq_line, wake, irq;
    int mismatches = 0, cmp_count = 0, cycles = 0, wakes = 0;

    // ****************************************
    // Design, board and clock
    // ****************************************
    pio_top i_dut (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .first_pin_in(a_in), .first_pin_out(a_out), .first_pin_oe_out(a_oe),
        .second_pin_in(b_in), .second_pin_out(b_out), .second_pin_oe_out(b_oe),
        .spi_en_in(spi_en), .pwm_en_in(pwm_en), .tmr_en_in(tmr_en), .periph_out_in(p_out),
        .periph_oe_in(p_oe), .periph_pin_out(b_per), .third_pin_in(c_in),
        .third_pin_out(c_out), .third_pin_oe_out(c_oe), .analog_inputs_0_to_4_in(an_in),
        .adc_active_in(adc_on), .adc_channel_in(chan), .stop_mode_in(stop_in),
        .cpu_irq_line_out(irq_line), .stop_wake_out(wake), .irq_out(irq));
    pio_pins_model #(.W(7)) i_pa (.drive_in(a_out), .oe_in(a_oe), .ext_en_in(ext_en[6:0]),
        .ext_val_in(ext_val[6:0]), .level_out(a_in));
    pio_pins_model i_pb (.drive_in(b_out), .oe_in(b_oe), .ext_en_in(ext_en),
        .ext_val_in(ext_val), .level_out(b_in));
    pio_pins_model i_pc (.drive_in(c_out), .oe_in(c_oe), .ext_en_in(ext_en),
        .ext_val_in(c_val), .level_out(c_in));

    always #12.5 ref_clk_in = ~ref_clk_in;

    // Count wake pulses and cut a hang short
    always @(posedge ref_clk_in) begin
        cycles <= cycles + 1;
        if (wake === 1'b1) wakes <= wakes + 1;
        if (cycles == 3000) begin
            mismatches++;
            end_sim();
        end
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        wr_in <= w;
        rd_in <= !w;
        addr_in <= a;
        wdata_in <= d;
        @(posedge ref_clk_in);
        wr_in <= 1'b0;
        rd_in <= 1'b0;
        #1;
    endtask : bus

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rdata_out, exp);
    endtask : rd

    task automatic wait_n(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask : wait_n

    task automatic end_sim();
        $display("compares=%0d mismatches=%0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        repeat (20) @(posedge ref_clk_in);
        reset_in <= 1'b0;
        for (int i = 4; i < 10; i++) rd(8'(i * 4), 0);
        bus(1, 8'h00, 32'hff);
        bus(1, 8'h10, 32'hff);
        rd(8'h10, 32'h7f);
        rd(8'h00, 32'h7f);
        chk(a_out, 7'h7f);
        chk(a_oe, 7'h7f);
        rd(8'h1c, 0);
        bus(1, 8'h04, 32'ha5);
        bus(1, 8'h14, 32'h0f);
        @(posedge ref_clk_in) ext_val <= 8'h3c;
        rd(8'h04, 32'h35);
        chk(b_out & b_oe, 8'h05);
        // Hand each shared group to its peripheral in turn
        for (int g = 0; g < 3; g++) begin
            @(posedge ref_clk_in) {tmr_en, pwm_en, spi_en} <= 3'(1 << g);
            wait_n(3);
            m = (g == 0) ? 8'h0f : (g == 1) ? 8'h30 : 8'hc0;
            chk(b_oe, 8'h0f | m);
            chk(b_out & b_oe, (8'h05 & ~m) | (8'h5a & m));
            chk(b_per, b_in);
        end
        @(posedge ref_clk_in) {tmr_en, pwm_en, spi_en} <= 3'h0;
        bus(1, 8'h0c, 32'h0);
        rd(8'h0c, 32'h1f);
        @(posedge ref_clk_in) adc_on <= 1'b1;
        for (int ch = 0; ch < 8; ch++) begin
            @(posedge ref_clk_in) chan <= 3'(ch);
            rd(8'h0c, (ch < 5) ? 32'h1f & ~(32'h1 << ch) : 32'h1f);
        end
        @(posedge ref_clk_in) adc_on <= 1'b0;
        // Third port: bit 1 gated by data, bit 2 an output driving low
        bus(1, 8'h24, 32'hff);
        bus(1, 8'h08, 32'h02);
        bus(1, 8'h18, 32'h04);
        @(posedge ref_clk_in) stop_in <= 1'b1;
        wait_n(2);
        chk(c_oe, 8'h04);
        chk(c_out, 8'h02);
        rd(8'h20, 0);
        @(posedge ref_clk_in) c_val <= 8'hf4;
        wait_n(3);
        chk(irq_line, 0);
        rd(8'h20, 32'h09);
        chk(irq, 1);
        chk(wakes, 1);
        bus(1, 8'h20, 32'h09);
        wait_n(3);
        rd(8'h20, 0);
        chk(irq, 0);
        @(posedge ref_clk_in) c_val <= 8'hff;
        bus(1, 8'h24, 32'h00);
        @(posedge ref_clk_in) c_val <= 8'hfe;
        wait_n(3);
        chk(irq, 0);
        bus(1, 8'h08, 32'h06);
        bus(1, 8'h08, 32'h02);
        wait_n(3);
        rd(8'h20, 32'h01);
        chk(wakes, 2);
        chk(irq_line, 0);
        @(posedge ref_clk_in) c_val <= 8'hff;
        bus(1, 8'h18, 32'hff);
        wait_n(5);
        // All outputs: a driven fall on bit 1 must not wake
        bus(1, 8'h08, 32'h00);
        wait_n(3);
        chk(wakes, 2);
        // Second reset keeps data registers
        @(posedge ref_clk_in) reset_in <= 1'b1;
        wait_n(2);
        @(posedge ref_clk_in) reset_in <= 1'b0;
        rd(8'h10, 0);
        bus(1, 8'h10, 32'h7f);
        rd(8'h00, 32'h7f);
        end_sim();
    end
endmodule : test_parallel_io_ports
